// file: src/afecd_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef AFECD_MAP_SVH
`define AFECD_MAP_SVH

// Register indices on the plain port
`define AFECD_ADDR_W 2
`define AFECD_DATA_W 8
`define AFECD_REG_CFG0 2'h0
`define AFECD_REG_CFG1 2'h1
`define AFECD_REG_CUR 2'h2
`define AFECD_REG_STAT 2'h3

// Fields of the first configuration register
`define AFECD_MUX_MSB 7
`define AFECD_MUX_LSB 4
`define AFECD_GAIN_MSB 3
`define AFECD_GAIN_LSB 1
`define AFECD_BYP_BIT 0

// Fields of the second configuration register
`define AFECD_REF_MSB 7
`define AFECD_REF_LSB 6
`define AFECD_TURBO_BIT 5

// Current source routing fields
`define AFECD_CUR1_MSB 2
`define AFECD_CUR1_LSB 0
`define AFECD_CUR2_MSB 6
`define AFECD_CUR2_LSB 4

// Reset values
`define AFECD_CFG0_RST 8'h00
`define AFECD_CFG1_RST 8'h00
`define AFECD_CUR_RST 8'h00

// Gain codes (log2 of the gain)
`define AFECD_GAIN_SC_MAX 3'h2
`define AFECD_SC_DIV 3'h2

// Rates and times
`define AFECD_SYS_KHZ 100000
`define AFECD_OSC_NORM_KHZ 1024
`define AFECD_OSC_TURBO_KHZ 2048
`define AFECD_MOD_DIV 4
`define AFECD_NCO_W 24
`define AFECD_NCO_INC(khz) ((64'(khz) << `AFECD_NCO_W) / 64'(`AFECD_SYS_KHZ))
`define AFECD_SYS_PERIOD_NS 10
`define AFECD_REF_SETTLE_NS 25000
`define AFECD_REF_SETTLE_CYC (`AFECD_REF_SETTLE_NS / `AFECD_SYS_PERIOD_NS)

`endif

// file: src/afecd_pkg.sv
// Types shared by the front end decode block
package afecd_pkg;

   // Converter input node selection
   typedef enum logic [2:0] {
      AFECD_AIN0,
      AFECD_AIN1,
      AFECD_AIN2,
      AFECD_AIN3,
      AFECD_SUPPLY_MON,
      AFECD_REF_MON,
      AFECD_NEG_SUPPLY,
      AFECD_MID
   } afecd_node_t;

   // Reference source selection
   typedef enum logic [1:0] {
      AFECD_REF_INT,
      AFECD_REF_EXT,
      AFECD_REF_SUPPLY,
      AFECD_REF_SUPPLY_ALT
   } afecd_ref_t;

   // Reference settling tracker states
   typedef enum logic {
      AFECD_SETTLED,
      AFECD_SETTLING
   } afecd_settle_t;

endpackage

// file: src/afecd_nco.sv
// Phase accumulator that derives the core oscillator tick
`timescale 1ns/1ps
`default_nettype none

module afecd_nco #(
   parameter int ACC_W = 24
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Rate
   input wire logic [ACC_W-1:0] phase_inc,
   // Tick
   output logic tick
);

   logic [ACC_W-1:0] acc_ff;
   logic [ACC_W:0] nxt_sum;
   logic tick_ff;

   // Carry out of the accumulator marks one oscillator period
   assign nxt_sum = {1'b0, acc_ff} + {1'b0, phase_inc};

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_ff <= '0;
      end else begin
         acc_ff <= nxt_sum[ACC_W-1:0];
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= nxt_sum[ACC_W];
      end
   end

   assign tick = tick_ff;

endmodule // afecd_nco

`default_nettype wire

// file: src/afecd_front_end.sv
// Front end configuration decode: routing, gain split, reference, clocks
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "afecd_map.svh"

// Behaviour
// R1 - Four-bit field selects input pairing
// R2 - Single-ended ties negative input to supply
// R3 - Monitor selects supply/4 or reference/4
// R4 - Either current source routes anywhere
// R5 - Three-bit gain field, gains 1 to 128
// R6 - Gain split between amplifier and capacitor
// R7 - Gains 1,2,4 use capacitor stage only
// R8 - Bypass bit disables amplifier at low gain
// R9 - Codes 1000-1011 force amplifier off
// R10 - Forced bypass clamps gain to four
// R11 - Two-bit reference select, internal after reset
// R12 - Supply difference is third reference
// R13 - External reference enables input buffers
// R14 - Host waits 25 us for internal reference
// R15 - Modulator runs at oscillator over four
// R16 - Oscillator 1.024 or 2.048 MHz by mode
// R17 - New settings apply at next conversion
module afecd_front_end #(
   parameter int ADDR_W = `AFECD_ADDR_W,
   parameter int DATA_W = `AFECD_DATA_W,
   parameter int NCO_W = `AFECD_NCO_W,
   parameter int SETTLE_CYC = `AFECD_REF_SETTLE_CYC
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // Conversion sequencing
   input wire logic conv_start,
   // Input routing
   output afecd_pkg::afecd_node_t pos_node,
   output afecd_pkg::afecd_node_t neg_node,
   output logic neg_supply_sw,
   // Gain stages
   output logic amp_en,
   output logic amp_bypass,
   output logic [2:0] amp_gain,
   output logic [2:0] sc_gain,
   // Reference
   output afecd_pkg::afecd_ref_t ref_sel,
   output logic ref_buf_en,
   output logic ref_settling,
   // Current source routing, one-hot AIN0-3, REFERENCE_POS_PIN, REFERENCE_NEG_PIN
   output logic [5:0] cur1_route,
   output logic [5:0] cur2_route,
   // Clocking
   output logic turbo,
   output logic osc_tick,
   output logic mod_tick
);

   import afecd_pkg::*;

   localparam logic [NCO_W-1:0] INC_NORM =
      NCO_W'(`AFECD_NCO_INC(`AFECD_OSC_NORM_KHZ));
   localparam logic [NCO_W-1:0] INC_TURBO =
      NCO_W'(`AFECD_NCO_INC(`AFECD_OSC_TURBO_KHZ));
   localparam int SET_W = $clog2(SETTLE_CYC + 1);

   // Pending settings as software wrote them
   logic [7:0] cfg0_ff;
   logic [7:0] cfg1_ff;
   logic [7:0] cur_ff;
   // Settings in force for the running conversion
   logic [7:0] act0_ff;
   logic [7:0] act1_ff;
   logic [7:0] act_cur_ff;
   logic [DATA_W-1:0] rdata_ff;

   logic [3:0] mux;
   logic [2:0] gain;
   logic byp_bit;
   logic [1:0] ref_code;
   logic forced;
   logic [2:0] eff_gain;
   logic nxt_bypass;

   afecd_node_t pos_ff;
   afecd_node_t neg_ff;
   afecd_node_t nxt_pos;
   afecd_node_t nxt_neg;
   logic neg_sw_ff;
   logic amp_en_ff;
   logic amp_byp_ff;
   logic [2:0] amp_gain_ff;
   logic [2:0] sc_gain_ff;
   afecd_ref_t ref_ff;
   afecd_ref_t nxt_ref;
   logic ref_buf_ff;
   logic [5:0] cur_route_ff [2];
   logic [1:0] mod_cnt_ff;
   logic mod_tick_ff;
   logic osc_tk;
   afecd_settle_t settle_state_ff;
   logic [SET_W-1:0] settle_cnt_ff;

   // Register writes
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg0_ff <= `AFECD_CFG0_RST;
         cfg1_ff <= `AFECD_CFG1_RST;
         cur_ff <= `AFECD_CUR_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            `AFECD_REG_CFG0: cfg0_ff <= reg_wdata[7:0];
            `AFECD_REG_CFG1: cfg1_ff <= reg_wdata[7:0];
            `AFECD_REG_CUR: cur_ff <= reg_wdata[7:0];
            default: ;
         endcase
      end
   end

   // Pending settings take effect only as a conversion begins, so a
   // conversion in progress never sees its routing or gain move
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         act0_ff <= `AFECD_CFG0_RST;
         act1_ff <= `AFECD_CFG1_RST;
         act_cur_ff <= `AFECD_CUR_RST;
      end else if (conv_start) begin // R17
         act0_ff <= cfg0_ff;
         act1_ff <= cfg1_ff;
         act_cur_ff <= cur_ff;
      end
   end

   // Register reads; unmapped reads return zero
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            `AFECD_REG_CFG0: rdata_ff <= DATA_W'(cfg0_ff);
            `AFECD_REG_CFG1: rdata_ff <= DATA_W'(cfg1_ff);
            `AFECD_REG_CUR: rdata_ff <= DATA_W'(cur_ff);
            `AFECD_REG_STAT: rdata_ff <= DATA_W'({ref_settling, amp_en_ff,
               amp_byp_ff, neg_sw_ff, 1'b0, sc_gain_ff});
            default: rdata_ff <= '0;
         endcase
      end else begin
         rdata_ff <= '0;
      end
   end

   assign reg_rdata = rdata_ff;

   // Field extraction from the settings in force
   assign mux = act0_ff[`AFECD_MUX_MSB:`AFECD_MUX_LSB]; // R1
   assign gain = act0_ff[`AFECD_GAIN_MSB:`AFECD_GAIN_LSB]; // R5
   assign byp_bit = act0_ff[`AFECD_BYP_BIT];
   assign ref_code = act1_ff[`AFECD_REF_MSB:`AFECD_REF_LSB]; // R11

   // Single-ended codes against the negative supply
   assign forced = (mux[3:2] == 2'b10); // R9

   // Gain above four cannot be reached without the amplifier
   assign eff_gain = (forced && gain > `AFECD_GAIN_SC_MAX) ?
      `AFECD_GAIN_SC_MAX : gain; // R10

   // Low gains survive bypass since the capacitor stage does them alone
   assign nxt_bypass = forced ||
      (byp_bit && eff_gain <= `AFECD_GAIN_SC_MAX); // R8 R7

   // Input multiplexer decode
   always_comb begin
      nxt_pos = AFECD_MID;
      nxt_neg = AFECD_MID;
      case (mux) // R1
         4'h0: begin
            nxt_pos = AFECD_AIN0;
            nxt_neg = AFECD_AIN1;
         end
         4'h1: begin
            nxt_pos = AFECD_AIN0;
            nxt_neg = AFECD_AIN2;
         end
         4'h2: begin
            nxt_pos = AFECD_AIN0;
            nxt_neg = AFECD_AIN3;
         end
         4'h3: begin
            nxt_pos = AFECD_AIN1;
            nxt_neg = AFECD_AIN0;
         end
         4'h4: begin
            nxt_pos = AFECD_AIN1;
            nxt_neg = AFECD_AIN2;
         end
         4'h5: begin
            nxt_pos = AFECD_AIN1;
            nxt_neg = AFECD_AIN3;
         end
         4'h6: begin
            nxt_pos = AFECD_AIN2;
            nxt_neg = AFECD_AIN3;
         end
         4'h7: begin
            nxt_pos = AFECD_AIN3;
            nxt_neg = AFECD_AIN2;
         end
         4'h8, 4'h9, 4'ha, 4'hb: begin
            nxt_pos = afecd_node_t'({1'b0, mux[1:0]});
            nxt_neg = AFECD_NEG_SUPPLY; // R2
         end
         4'hc: begin
            nxt_pos = AFECD_REF_MON; // R3
            nxt_neg = AFECD_REF_MON;
         end
         4'hd: begin
            nxt_pos = AFECD_SUPPLY_MON; // R3
            nxt_neg = AFECD_SUPPLY_MON;
         end
         default: begin
            nxt_pos = AFECD_MID;
            nxt_neg = AFECD_MID;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pos_ff <= AFECD_AIN0;
         neg_ff <= AFECD_AIN1;
         neg_sw_ff <= 1'b0;
      end else begin
         pos_ff <= nxt_pos;
         neg_ff <= nxt_neg;
         neg_sw_ff <= forced; // R2
      end
   end

   // Gain split: capacitor stage takes up to four, amplifier the rest
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         amp_gain_ff <= 3'h0;
         sc_gain_ff <= 3'h0;
      end else if (eff_gain > `AFECD_GAIN_SC_MAX) begin
         amp_gain_ff <= eff_gain - `AFECD_SC_DIV; // R6
         sc_gain_ff <= `AFECD_GAIN_SC_MAX;
      end else begin
         amp_gain_ff <= 3'h0; // R7
         sc_gain_ff <= eff_gain;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         amp_en_ff <= 1'b1;
         amp_byp_ff <= 1'b0;
      end else begin
         amp_en_ff <= !nxt_bypass; // R8 R9
         amp_byp_ff <= nxt_bypass;
      end
   end

   // Reference selection; the spare code also picks the supply
   always_comb begin
      case (ref_code)
         2'h0: nxt_ref = AFECD_REF_INT; // R11
         2'h1: nxt_ref = AFECD_REF_EXT;
         default: nxt_ref = AFECD_REF_SUPPLY; // R12
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_ff <= AFECD_REF_INT; // R11
         ref_buf_ff <= 1'b0;
      end else begin
         ref_ff <= nxt_ref;
         ref_buf_ff <= (nxt_ref == AFECD_REF_EXT); // R13
      end
   end

   // Flags the internal reference as unsettled after power-up and after
   // a move from an external source; the host must wait it out
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         settle_state_ff <= AFECD_SETTLING;
         settle_cnt_ff <= '0;
      end else if (ref_ff == AFECD_REF_EXT && nxt_ref == AFECD_REF_INT) begin
         settle_state_ff <= AFECD_SETTLING; // R14
         settle_cnt_ff <= '0;
      end else begin
         case (settle_state_ff)
            AFECD_SETTLING: begin
               if (settle_cnt_ff == SET_W'(SETTLE_CYC - 1)) begin
                  settle_state_ff <= AFECD_SETTLED;
               end
               settle_cnt_ff <= settle_cnt_ff + 1'b1;
            end
            AFECD_SETTLED: settle_cnt_ff <= '0;
            default: settle_state_ff <= AFECD_SETTLED;
         endcase
      end
   end

   assign ref_settling = (settle_state_ff == AFECD_SETTLING);

   // Current source routing: code 0 is off, 1-6 pick one destination
   for (genvar i = 0; i < 2; i++) begin : g_cur
      logic [2:0] code;
      assign code = (i == 0) ?
         act_cur_ff[`AFECD_CUR1_MSB:`AFECD_CUR1_LSB] :
         act_cur_ff[`AFECD_CUR2_MSB:`AFECD_CUR2_LSB];
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            cur_route_ff[i] <= 6'h00;
         end else if (code == 3'h0 || code == 3'h7) begin
            cur_route_ff[i] <= 6'h00;
         end else begin
            cur_route_ff[i] <= 6'(6'h01 << (code - 3'h1)); // R4
         end
      end
   end

   // Oscillator rate follows the applied mode bit
   assign turbo = act1_ff[`AFECD_TURBO_BIT];

   afecd_nco #(
      .ACC_W(NCO_W)
   ) u_nco (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .phase_inc(turbo ? INC_TURBO : INC_NORM), // R16
      .tick(osc_tk)
   );

   // Modulator ticks once every four oscillator ticks
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mod_cnt_ff <= 2'h0;
         mod_tick_ff <= 1'b0;
      end else begin
         if (osc_tk) begin
            mod_cnt_ff <= mod_cnt_ff + 2'h1; // R15
         end
         mod_tick_ff <= osc_tk &&
            (mod_cnt_ff == 2'(`AFECD_MOD_DIV - 1)); // R15
      end
   end

   assign pos_node = pos_ff;
   assign neg_node = neg_ff;
   assign neg_supply_sw = neg_sw_ff;
   assign amp_en = amp_en_ff;
   assign amp_bypass = amp_byp_ff;
   assign amp_gain = amp_gain_ff;
   assign sc_gain = sc_gain_ff;
   assign ref_sel = ref_ff;
   assign ref_buf_en = ref_buf_ff;
   assign cur1_route = cur_route_ff[0];
   assign cur2_route = cur_route_ff[1];
   assign osc_tick = osc_tk;
   assign mod_tick = mod_tick_ff;

endmodule // afecd_front_end

`default_nettype wire

// file: verification/afecd_front_end_monitor.sv
// Assertion checker for the front end configuration decode
`timescale 1ns/1ps
`default_nettype none
module afecd_front_end_monitor #(
   parameter int SETTLE_CYC = 20
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Sequencing
   input wire logic conv_start,
   // Routing and gain
   input wire afecd_pkg::afecd_node_t neg_node,
   input wire afecd_pkg::afecd_node_t pos_node,
   input wire logic neg_supply_sw,
   input wire logic amp_en,
   input wire logic amp_bypass,
   input wire logic [2:0] amp_gain,
   input wire logic [2:0] sc_gain,
   // Reference and clocks
   input wire afecd_pkg::afecd_ref_t ref_sel,
   input wire logic ref_buf_en,
   input wire logic ref_settling,
   input wire logic osc_tick,
   input wire logic mod_tick
);
   import afecd_pkg::*;
   logic [15:0] settle_cnt_ff;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // A counter, since the settling spell is far longer than a repetition may be
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) settle_cnt_ff <= 16'h0000;
      else if (ref_settling) settle_cnt_ff <= settle_cnt_ff + 16'h0001;
      else settle_cnt_ff <= 16'h0000;
   end
   sequence s_quiet;
      !conv_start [*3];
   endsequence
   amp_pair_a: assert property (amp_bypass == !amp_en)
      else $error("bypass and enable disagree");
   ref_buffer_a: assert property (ref_buf_en == (ref_sel == AFECD_REF_EXT))
      else $error("reference buffer wrong");
   neg_tie_a: assert property (neg_supply_sw == (neg_node == AFECD_NEG_SUPPLY))
      else $error("negative supply switch wrong");
   forced_off_a: assert property (neg_supply_sw |-> !amp_en && amp_gain == 3'h0)
      else $error("amplifier not forced off");
   gain_split_a: assert property (amp_gain != 3'h0 |-> sc_gain == 3'h2 && amp_en)
      else $error("gain split wrong");
   bypass_gain_a: assert property (!amp_en |-> amp_gain == 3'h0 && sc_gain <= 3'h2)
      else $error("bypassed gain wrong");
   mod_clock_a: assert property (mod_tick |-> $past(osc_tick))
      else $error("modulator tick without oscillator tick");
   next_conv_a: assert property (s_quiet |=> $stable(sc_gain) && $stable(amp_en)
      && $stable(pos_node) && $stable(ref_sel))
      else $error("settings changed without a conversion");
   settle_bound_a: assert property (settle_cnt_ff <= 16'(SETTLE_CYC + 2))
      else $error("reference settling too long");
endmodule // afecd_front_end_monitor
bind afecd_front_end afecd_front_end_monitor #(.SETTLE_CYC(SETTLE_CYC)) u_afecd_front_end_monitor (
   .sys_clk(sys_clk), .rst_n(rst_n), .conv_start(conv_start), .neg_node(neg_node),
   .pos_node(pos_node), .neg_supply_sw(neg_supply_sw), .amp_en(amp_en),
   .amp_bypass(amp_bypass), .amp_gain(amp_gain), .sc_gain(sc_gain), .ref_sel(ref_sel),
   .ref_buf_en(ref_buf_en), .ref_settling(ref_settling), .osc_tick(osc_tick),
   .mod_tick(mod_tick)
);
`default_nettype wire

// file: verification/afecd_front_end_tb.sv
// Self-checking testbench for the front end configuration decode
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin miscompares++; $display("wrong value at %0t: %s", $time, m); end end
module afecd_front_end_tb;
   import afecd_pkg::*;
   localparam int SETTLE = 20;
   localparam logic [2:0] POS [16] = '{0, 0, 0, 1, 1, 1, 2, 3, 0, 1, 2, 3, 5, 4, 7, 7};
   localparam logic [2:0] NEG [16] = '{1, 2, 3, 0, 2, 3, 3, 2, 6, 6, 6, 6, 5, 4, 7, 7};
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic conv_start = 1'b0;
   logic [7:0] reg_rdata, d;
   afecd_node_t pos_node, neg_node;
   afecd_ref_t ref_sel;
   logic neg_supply_sw, amp_en, amp_bypass, ref_buf_en, ref_settling, turbo, osc_tick, mod_tick;
   logic [2:0] amp_gain, sc_gain;
   logic [5:0] cur1_route, cur2_route;
   int miscompares = 0;
   int n_checks = 0;
   int cyc = 0;
   int no, nm;
   always #5 sys_clk = ~sys_clk;
   afecd_front_end #(.SETTLE_CYC(SETTLE)) u_afecd_front_end (
      .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start),
      .pos_node(pos_node), .neg_node(neg_node), .neg_supply_sw(neg_supply_sw),
      .amp_en(amp_en), .amp_bypass(amp_bypass), .amp_gain(amp_gain), .sc_gain(sc_gain),
      .ref_sel(ref_sel), .ref_buf_en(ref_buf_en), .ref_settling(ref_settling),
      .cur1_route(cur1_route), .cur2_route(cur2_route), .turbo(turbo),
      .osc_tick(osc_tick), .mod_tick(mod_tick)
   );
   task automatic end_sim;
      if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         end_sim();
      end
   end
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [7:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   // Settings only take hold at a conversion start, so every change goes through here
   task automatic apply(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] cur);
      wr(2'h0, c0);
      wr(2'h1, c1);
      wr(2'h2, cur);
      @(posedge sys_clk) conv_start <= 1'b1;
      @(posedge sys_clk) conv_start <= 1'b0;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask
   function automatic logic [5:0] oh(input int c);
      return (c >= 1 && c <= 6) ? 6'h01 << (c - 1) : 6'h00;
   endfunction
   task automatic t_regs;
      repeat (SETTLE + 5) @(posedge sys_clk);
      #1 `CHK(ref_settling, 1'b0, "settling not done")
      wr(2'h3, 8'hff);
      rd(2'h3, d);
      `CHK(d, 8'h40, "status value")
      @(posedge sys_clk);
      #1 `CHK(reg_rdata, 8'h00, "read data held over")
      wr(2'h0, 8'h8e);
      rd(2'h0, d);
      `CHK(d, 8'h8e, "config readback")
      `CHK(neg_supply_sw, 1'b0, "applied before conversion")
      `CHK(amp_en, 1'b1, "applied before conversion")
   endtask
   task automatic t_mux;
      for (int m = 0; m < 16; m++) begin
         apply({4'(m), 4'h0}, 8'h00, 8'h00);
         `CHK(pos_node, afecd_node_t'(POS[m]), "positive node")
         `CHK(neg_node, afecd_node_t'(NEG[m]), "negative node")
         `CHK(neg_supply_sw, 1'(m >= 8 && m <= 11), "supply switch")
         `CHK(amp_en, 1'(m < 8 || m > 11), "forced bypass")
      end
   endtask
   task automatic t_gain;
      for (int g = 0; g < 8; g++) begin
         for (int b = 0; b < 2; b++) begin
            apply({4'h0, 3'(g), 1'(b)}, 8'h00, 8'h00);
            `CHK(sc_gain, 3'(g > 2 ? 2 : g), "capacitor gain")
            `CHK(amp_gain, 3'(g > 2 ? g - 2 : 0), "amplifier gain")
            `CHK(amp_en, 1'(!(b == 1 && g <= 2)), "bypass")
            `CHK(amp_bypass, 1'(b == 1 && g <= 2), "bypass flag")
         end
         apply({4'(8 + g % 4), 3'(g), 1'b0}, 8'h00, 8'h00);
         `CHK(amp_en, 1'b0, "forced off")
         `CHK(amp_bypass, 1'b1, "forced bypass flag")
         `CHK(sc_gain, 3'(g > 2 ? 2 : g), "clamped gain")
         `CHK(amp_gain, 3'h0, "clamped gain")
      end
   endtask
   task automatic t_ref;
      for (int r = 0; r < 4; r++) begin
         apply(8'h00, {2'(r), 6'h00}, 8'h00);
         `CHK(ref_sel, afecd_ref_t'(r == 3 ? 2 : r), "reference")
         `CHK(ref_buf_en, 1'(r == 1), "reference buffer")
      end
      apply(8'h00, 8'h40, 8'h00);
      apply(8'h00, 8'h00, 8'h00);
      `CHK(ref_settling, 1'b1, "settling restart")
      repeat (SETTLE + 5) @(posedge sys_clk);
      #1 `CHK(ref_settling, 1'b0, "settling end")
   endtask
   task automatic t_cur;
      for (int c = 0; c < 8; c++) begin
         apply(8'h00, 8'h00, {1'b0, 3'(7 - c), 1'b0, 3'(c)});
         `CHK(cur1_route, oh(c), "source one route")
         `CHK(cur2_route, oh(7 - c), "source two route")
      end
   endtask
   task automatic t_clk;
      for (int t = 0; t < 2; t++) begin
         apply(8'h00, {2'h0, 1'(t), 5'h00}, 8'h00);
         `CHK(turbo, 1'(t), "mode")
         no = 0;
         nm = 0;
         repeat (10000) begin
            @(posedge sys_clk);
            #1 no += int'(osc_tick);
            nm += int'(mod_tick);
         end
         `CHK(1'(no >= (t ? 204 : 101) && no <= (t ? 206 : 104)), 1'b1, "oscillator rate")
         `CHK(1'(nm * 4 >= no - 4 && nm * 4 <= no + 4), 1'b1, "modulator rate")
      end
   endtask
   initial begin
      repeat (19) @(posedge sys_clk);
      #1 `CHK(ref_sel, AFECD_REF_INT, "reset reference")
      `CHK(ref_settling, 1'b1, "reset settling")
      // Release on a rising edge so reset spans twenty edges
      @(posedge sys_clk) rst_n <= 1'b1;
      t_regs();
      t_mux();
      t_gain();
      t_ref();
      t_cur();
      t_clk();
      end_sim();
   end
endmodule // afecd_front_end_tb
`default_nettype wire
